// ### hdl/asc_cfg_bank.v
/*
 * Slot and master clock configuration bank of the audio serial port.
 * Holds the channel five and six slot registers, the two master clock
 * registers and the reference frequency mode bit, and decodes them into
 * registered control outputs for the serial port and clock generator.
 * Assumes an Avalon-MM master on sys_clk_i with 32-bit data and byte
 * addresses; all inputs come from the same clock domain.
 */
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
`include "asc_defines.vh"

// Summary of operation
// - Each channel has a 6-bit slot field whose codes 0 to 31 pick that TDM slot or left slot.
// - Slot codes 32 to 63 pick TDM slots 32 to 63 or right slots 0 to 31 in two-channel formats.
// - Bit 6 of a channel slot register clear routes the channel to the primary serial output.
// - After reset channel five sits in slot 4 and channel six in slot 5, on six-channel parts.
// - Bit 7 of config A clear takes bit clock and frame sync as inputs; set drives both.
// - Config A bit 6 clear lets the device derive dividers and PLL; set selects custom settings.
// - In automatic configuration the PLL runs while config A bit 5 is 0 and stops while it is 1.
// - In master mode config A bit 4 set gates off the sent clocks; it has no effect as slave.
// - In master mode config A bit 3 picks the 48 kHz family at 0 and the 44.1 kHz family at 1.
// - In master mode with table selection, config A bits 2:0 give the reference clock, reset 2.
// - Config B holds a sample-rate code in bits 7:4 reset 4 and a ratio code in 3:0 reset 8.
// - Rate codes 0 to 8 span 8 to 768 kHz (48 kHz family) or 7.35 to 705.6 kHz (44.1 kHz family), 9 to 15 reserved, unused as auto slave.
// - Ratio codes span 16 to 2048 bit clocks per frame, 14 means 144, 13 and 15 are reserved.
// - A frequency mode bit takes the reference from the table at 0 or from frame rate at 1.
module asc_cfg_bank #(
    parameter SIX_CHANNEL = 1
) (
    input  wire                          sys_clk_i,
    input  wire                          sys_rst_i,
    input  wire [`ASC_ADDR_W-1:0]        avs_address_i,
    input  wire                          avs_read_i,
    input  wire                          avs_write_i,
    input  wire [`ASC_DATA_W-1:0]        avs_writedata_i,
    input  wire [3:0]                    avs_byteenable_i,
    output reg  [`ASC_DATA_W-1:0]        avs_readdata_o,
    output reg                           avs_waitrequest_o,
    output wire [`ASC_SLOT_W-1:0]        chan5_slot_sel_o,
    output wire                          chan5_out_line_sel_o,
    output wire                          chan5_right_half_o,
    output wire [`ASC_HALF_SLOT_W-1:0]   chan5_half_slot_o,
    output wire [`ASC_SLOT_W-1:0]        chan6_slot_sel_o,
    output wire                          chan6_out_line_sel_o,
    output wire                          chan6_right_half_o,
    output wire [`ASC_HALF_SLOT_W-1:0]   chan6_half_slot_o,
    output reg                           clock_role_sel_o,
    output reg                           auto_derive_o,
    output reg                           pll_enable_o,
    output reg                           serial_clock_run_o,
    output reg                           rate_family_sel_o,
    output reg                           ref_from_table_o,
    output reg  [`ASC_REF_KHZ_W-1:0]     ref_clock_khz_o,
    output reg                           rate_cfg_used_o,
    output reg  [`ASC_RATE_HZ_W-1:0]     sample_rate_hz_o,
    output reg                           sample_rate_ok_o,
    output reg  [`ASC_BPF_W-1:0]         bits_per_frame_o,
    output reg                           bits_per_frame_ok_o
);

    // Stored registers
    reg  [`ASC_REG_W-1:0]        chan5_cfg_q;
    reg  [`ASC_REG_W-1:0]        chan6_cfg_q;
    reg  [`ASC_REG_W-1:0]        cfg_a_q;
    reg  [`ASC_REG_W-1:0]        cfg_b_q;
    reg  [`ASC_REG_W-1:0]        ref_mode_q;

    // Bus handshake state
    reg                          req_live;
    reg                          wr_go;
    reg  [5:0]                   word_idx;
    reg                          idx_hit;
    reg  [`ASC_REG_W-1:0]        rd_byte;
    reg  [`ASC_DATA_W-1:0]       readdata_d;

    // Field views
    wire                         role_master;
    wire                         auto_mode;
    wire                         pll_off_bit;
    wire                         gate_bit;
    wire                         family_bit;
    wire [`ASC_REF_SEL_W-1:0]    ref_sel;
    wire [`ASC_CODE_W-1:0]       sample_rate_code;
    wire [`ASC_CODE_W-1:0]       bits_per_frame_code;
    wire                         ref_freq_spec_mode;

    // Decode results
    reg  [`ASC_MULT_W-1:0]       rate_mult;
    reg  [`ASC_BPF_W-1:0]        bpf_val;
    reg  [`ASC_REF_KHZ_W-1:0]    ref_khz_val;
    reg  [`ASC_RATE_HZ_W-1:0]    rate_base;
    wire [`ASC_RATE_HZ_W+`ASC_MULT_W-1:0] rate_prod;
    wire [`ASC_REG_W-1:0]        status_byte;

    // Channel registers on the decoder side, forced to zero without them
    wire [`ASC_REG_W-1:0]        chan_cfg [0:1];
    wire [`ASC_SLOT_W-1:0]       dec_slot [0:1];
    wire                         dec_line [0:1];
    wire                         dec_half [0:1];
    wire [`ASC_HALF_SLOT_W-1:0]  dec_hslot [0:1];

    assign role_master         = cfg_a_q[`ASC_ROLE_BIT];
    assign auto_mode           = ~cfg_a_q[`ASC_AUTO_CFG_BIT];
    assign pll_off_bit         = cfg_a_q[`ASC_AUTO_PLL_OFF_BIT];
    assign gate_bit            = cfg_a_q[`ASC_CLK_GATE_BIT];
    assign family_bit          = cfg_a_q[`ASC_FAMILY_BIT];
    assign ref_sel             = cfg_a_q[`ASC_REF_SEL_HI:0];
    assign sample_rate_code    = cfg_b_q[`ASC_RATE_HI:`ASC_RATE_LO];
    assign bits_per_frame_code = cfg_b_q[`ASC_RATIO_HI:`ASC_RATIO_LO];
    assign ref_freq_spec_mode  = ref_mode_q[`ASC_REF_MODE_BIT];

    // Bus decode; a write counts only on the cycle waitrequest is low
    always @* begin
        req_live = avs_read_i | avs_write_i;
        word_idx = avs_address_i[`ASC_ADDR_W-1:`ASC_WORD_LSB];
        wr_go    = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
        case (word_idx)
            `ASC_IDX_CHAN5_SLOT_CFG,
            `ASC_IDX_CHAN6_SLOT_CFG: idx_hit = (SIX_CHANNEL != 0);
            `ASC_IDX_MASTER_CFG_A,
            `ASC_IDX_MASTER_CFG_B,
            `ASC_IDX_REF_MODE_CFG,
            `ASC_IDX_CFG_STATUS:     idx_hit = 1'b1;
            default:                 idx_hit = 1'b0;
        endcase
    end

    // Live state of the block for software
    assign status_byte = {1'b0, ref_from_table_o, bits_per_frame_ok_o, sample_rate_ok_o,
                          serial_clock_run_o, pll_enable_o, auto_derive_o,
                          clock_role_sel_o};

    // Read mux; unmapped words and reserved bits read zero
    always @* begin
        case (word_idx)
            `ASC_IDX_CHAN5_SLOT_CFG: rd_byte = chan_cfg[0];
            `ASC_IDX_CHAN6_SLOT_CFG: rd_byte = chan_cfg[1];
            `ASC_IDX_MASTER_CFG_A:   rd_byte = cfg_a_q;
            `ASC_IDX_MASTER_CFG_B:   rd_byte = cfg_b_q;
            `ASC_IDX_REF_MODE_CFG:   rd_byte = ref_mode_q;
            `ASC_IDX_CFG_STATUS:     rd_byte = status_byte;
            default:                 rd_byte = {`ASC_REG_W{1'b0}};
        endcase
        readdata_d = {{(`ASC_DATA_W-`ASC_REG_W){1'b0}}, rd_byte};
        if (!idx_hit) begin
            readdata_d = {`ASC_DATA_W{1'b0}};
        end
    end

    // Waitrequest drops for one cycle per request; keeps the output on a flop
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= {`ASC_DATA_W{1'b0}};
        end else begin
            avs_waitrequest_o <= ~(req_live & avs_waitrequest_o);
            if (avs_read_i && avs_waitrequest_o) begin
                avs_readdata_o <= readdata_d;
            end
        end
    end

    // Register writes; only the low byte lane carries data
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            chan5_cfg_q <= `ASC_RST_CHAN5;
            chan6_cfg_q <= `ASC_RST_CHAN6;
            cfg_a_q     <= `ASC_RST_CFG_A;
            cfg_b_q     <= `ASC_RST_CFG_B;
            ref_mode_q  <= `ASC_RST_REF_MODE;
        end else if (wr_go) begin
            case (word_idx)
                `ASC_IDX_CHAN5_SLOT_CFG:
                    chan5_cfg_q <= avs_writedata_i[`ASC_REG_W-1:0] & `ASC_SLOT_CFG_MASK;
                `ASC_IDX_CHAN6_SLOT_CFG:
                    chan6_cfg_q <= avs_writedata_i[`ASC_REG_W-1:0] & `ASC_SLOT_CFG_MASK;
                `ASC_IDX_MASTER_CFG_A:
                    cfg_a_q <= avs_writedata_i[`ASC_REG_W-1:0];
                `ASC_IDX_MASTER_CFG_B:
                    cfg_b_q <= avs_writedata_i[`ASC_REG_W-1:0];
                `ASC_IDX_REF_MODE_CFG:
                    ref_mode_q <= avs_writedata_i[`ASC_REG_W-1:0] & `ASC_REF_MODE_MASK;
                default: ;
            endcase
        end
    end

    // Four-channel parts hide channels five and six entirely
    assign chan_cfg[0] = (SIX_CHANNEL != 0) ? chan5_cfg_q : {`ASC_REG_W{1'b0}};
    assign chan_cfg[1] = (SIX_CHANNEL != 0) ? chan6_cfg_q : {`ASC_REG_W{1'b0}};

    // One slot decoder per channel
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
            asc_slot_decode u_dec (
                .sys_clk_i      (sys_clk_i),
                .sys_rst_i      (sys_rst_i),
                .cfg_i          (chan_cfg[ch]),
                .slot_sel_o     (dec_slot[ch]),
                .out_line_sel_o (dec_line[ch]),
                .right_half_o   (dec_half[ch]),
                .half_slot_o    (dec_hslot[ch])
            );
        end
    endgenerate

    assign chan5_slot_sel_o     = dec_slot[0];
    assign chan5_out_line_sel_o = dec_line[0];
    assign chan5_right_half_o   = dec_half[0];
    assign chan5_half_slot_o    = dec_hslot[0];
    assign chan6_slot_sel_o     = dec_slot[1];
    assign chan6_out_line_sel_o = dec_line[1];
    assign chan6_right_half_o   = dec_half[1];
    assign chan6_half_slot_o    = dec_hslot[1];

    // Sample-rate multiplier over the family base; reserved codes give zero
    always @* begin
        case (sample_rate_code)
            4'h0:    rate_mult = 7'd1;
            4'h1:    rate_mult = 7'd2;
            4'h2:    rate_mult = 7'd3;
            4'h3:    rate_mult = 7'd4;
            4'h4:    rate_mult = 7'd6;
            4'h5:    rate_mult = 7'd12;
            4'h6:    rate_mult = 7'd24;
            4'h7:    rate_mult = 7'd48;
            4'h8:    rate_mult = 7'd96;
            default: rate_mult = 7'd0;
        endcase
        rate_base = family_bit ? `ASC_BASE_44K_HZ : `ASC_BASE_48K_HZ;
    end

    assign rate_prod = rate_base * rate_mult;

    // Bit clocks per frame; reserved codes give zero
    always @* begin
        case (bits_per_frame_code)
            4'h0:    bpf_val = 12'd16;
            4'h1:    bpf_val = 12'd24;
            4'h2:    bpf_val = 12'd32;
            4'h3:    bpf_val = 12'd48;
            4'h4:    bpf_val = 12'd64;
            4'h5:    bpf_val = 12'd96;
            4'h6:    bpf_val = 12'd128;
            4'h7:    bpf_val = 12'd192;
            4'h8:    bpf_val = 12'd256;
            4'h9:    bpf_val = 12'd384;
            4'hA:    bpf_val = 12'd512;
            4'hB:    bpf_val = 12'd1024;
            4'hC:    bpf_val = 12'd2048;
            4'hE:    bpf_val = 12'd144;
            default: bpf_val = 12'd0;
        endcase
    end

    // Reference clock table in kHz
    always @* begin
        case (ref_sel)
            3'h0:    ref_khz_val = 15'd12000;
            3'h1:    ref_khz_val = 15'd12288;
            3'h2:    ref_khz_val = 15'd13000;
            3'h3:    ref_khz_val = 15'd16000;
            3'h4:    ref_khz_val = 15'd19200;
            3'h5:    ref_khz_val = 15'd19680;
            3'h6:    ref_khz_val = 15'd24000;
            default: ref_khz_val = 15'd24576;
        endcase
    end

    // Registered control outputs for the serial port and clock tree
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            clock_role_sel_o    <= 1'b0;
            auto_derive_o       <= 1'b1;
            pll_enable_o        <= 1'b1;
            serial_clock_run_o  <= 1'b0;
            rate_family_sel_o   <= 1'b0;
            ref_from_table_o    <= 1'b0;
            ref_clock_khz_o     <= {`ASC_REF_KHZ_W{1'b0}};
            rate_cfg_used_o     <= 1'b0;
            sample_rate_hz_o    <= {`ASC_RATE_HZ_W{1'b0}};
            sample_rate_ok_o    <= 1'b0;
            bits_per_frame_o    <= {`ASC_BPF_W{1'b0}};
            bits_per_frame_ok_o <= 1'b0;
        end else begin
            // Role decides who drives bit clock and frame sync
            clock_role_sel_o    <= role_master;
            auto_derive_o       <= auto_mode;
            // Custom mode leaves the PLL to the custom settings, so off here
            pll_enable_o        <= auto_mode & ~pll_off_bit;
            // Gate only acts when this end sends the clocks
            serial_clock_run_o  <= role_master & ~gate_bit;
            rate_family_sel_o   <= role_master & family_bit;
            // Table value only counts for a master in table mode
            ref_from_table_o    <= role_master & ~ref_freq_spec_mode;
            ref_clock_khz_o     <= (role_master & ~ref_freq_spec_mode)
                                   ? ref_khz_val : {`ASC_REF_KHZ_W{1'b0}};
            // Rate fields are ignored by an automatic slave
            rate_cfg_used_o     <= role_master | ~auto_mode;
            sample_rate_hz_o    <= rate_prod[`ASC_RATE_HZ_W-1:0];
            sample_rate_ok_o    <= (sample_rate_code <= `ASC_RATE_MAX_CODE);
            bits_per_frame_o    <= bpf_val;
            bits_per_frame_ok_o <= (bits_per_frame_code != `ASC_RATIO_GAP_A) &&
                                   (bits_per_frame_code != `ASC_RATIO_GAP_B);
        end
    end

endmodule

// ### shared/asc_defines.vh
/*
 * Constants for the audio serial port slot and master clock register bank:
 * register indices, field positions, reset values and decode table bases.
 * Assumes inclusion by bare name from the design files; definitions only.
 */
`ifndef ASC_DEFINES_VH
`define ASC_DEFINES_VH

// Register indices; byte address is four times the index
`define ASC_IDX_CHAN5_SLOT_CFG   6'h0F
`define ASC_IDX_CHAN6_SLOT_CFG   6'h10
`define ASC_IDX_MASTER_CFG_A     6'h13
`define ASC_IDX_MASTER_CFG_B     6'h14
`define ASC_IDX_REF_MODE_CFG     6'h16
`define ASC_IDX_CFG_STATUS       6'h20

// Bus geometry
`define ASC_ADDR_W               8
`define ASC_WORD_LSB             2
`define ASC_DATA_W               32
`define ASC_REG_W                8

// Channel slot register fields
`define ASC_SLOT_HI              5
`define ASC_SLOT_W               6
`define ASC_OUT_LINE_BIT         6
`define ASC_HALF_BIT             5
`define ASC_HALF_SLOT_W          5
`define ASC_SLOT_CFG_MASK        8'h7F

// Master config A fields
`define ASC_ROLE_BIT             7
`define ASC_AUTO_CFG_BIT         6
`define ASC_AUTO_PLL_OFF_BIT     5
`define ASC_CLK_GATE_BIT         4
`define ASC_FAMILY_BIT           3
`define ASC_REF_SEL_HI           2
`define ASC_REF_SEL_W            3

// Master config B fields
`define ASC_RATE_HI              7
`define ASC_RATE_LO              4
`define ASC_RATIO_HI             3
`define ASC_RATIO_LO             0
`define ASC_CODE_W               4

// Reference frequency mode register field
`define ASC_REF_MODE_BIT         6
`define ASC_REF_MODE_MASK        8'h40

// Reset values
`define ASC_RST_CHAN5            8'h04
`define ASC_RST_CHAN6            8'h05
`define ASC_RST_CFG_A            8'h02
`define ASC_RST_CFG_B            8'h48
`define ASC_RST_REF_MODE         8'h00

// Highest legal rate code and reserved ratio codes
`define ASC_RATE_MAX_CODE        4'h8
`define ASC_RATIO_GAP_A          4'hD
`define ASC_RATIO_GAP_B          4'hF

// Rate family base rates in Hz, and output widths
`define ASC_BASE_48K_HZ          20'd8000
`define ASC_BASE_44K_HZ          20'd7350
`define ASC_RATE_HZ_W            20
`define ASC_MULT_W               7
`define ASC_BPF_W                12
`define ASC_REF_KHZ_W            15

`endif

// ### hdl/asc_slot_decode.v
/*
 * Per-channel slot decoder: splits a channel slot register into the slot
 * number, the output line choice and the two-channel half and slot.
 * Assumes the configuration byte comes from logic on the same clock.
 */
`timescale 1ns/1ps
`include "asc_defines.vh"

module asc_slot_decode (
    input  wire                          sys_clk_i,
    input  wire                          sys_rst_i,
    input  wire [`ASC_REG_W-1:0]         cfg_i,
    output reg  [`ASC_SLOT_W-1:0]        slot_sel_o,
    output reg                           out_line_sel_o,
    output reg                           right_half_o,
    output reg  [`ASC_HALF_SLOT_W-1:0]   half_slot_o
);

    // Registered so every decoded output leaves on a flop
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            slot_sel_o     <= {`ASC_SLOT_W{1'b0}};
            out_line_sel_o <= 1'b0;
            right_half_o   <= 1'b0;
            half_slot_o    <= {`ASC_HALF_SLOT_W{1'b0}};
        end else begin
            slot_sel_o     <= cfg_i[`ASC_SLOT_HI:0];
            out_line_sel_o <= cfg_i[`ASC_OUT_LINE_BIT];
            right_half_o   <= cfg_i[`ASC_HALF_BIT];
            half_slot_o    <= cfg_i[`ASC_HALF_SLOT_W-1:0];
        end
    end

endmodule

// ### sim/asc_far_host.sv
/*
 * Behavioural model of the host or DSP on the far side of the serial audio port.
 * Assumes it watches the decoded clock role and reference selection of the bank.
 */
`timescale 1ns/1ps

module asc_far_host (
    input  wire clock_role_sel_i,
    input  wire ref_from_table_i,
    output wire host_drives_clk_o,
    output wire host_supplies_ref_o
);
    // Host drives bit clock and frame sync only while the device is slave
    assign host_drives_clk_o = !clock_role_sel_i;
    // Reference clock offered only when the device picks it from the table
    assign host_supplies_ref_o = ref_from_table_i;
endmodule

// ### sim/asc_cfg_bank_sva.sv
/*
 * Checker for asc_cfg_bank: bus handshake and decode relations between outputs.
 * Assumes bind to asc_cfg_bank, one clock, synchronous active-high reset.
 */
`timescale 1ns/1ps

module asc_cfg_bank_sva (
    input wire        sys_clk_i,
    input wire        sys_rst_i,
    input wire        avs_read_i,
    input wire        avs_write_i,
    input wire        avs_waitrequest_o,
    input wire [5:0]  chan5_slot_sel_o,
    input wire        chan5_right_half_o,
    input wire [4:0]  chan5_half_slot_o,
    input wire        clock_role_sel_o,
    input wire        auto_derive_o,
    input wire        pll_enable_o,
    input wire        serial_clock_run_o,
    input wire        rate_family_sel_o,
    input wire        ref_from_table_o,
    input wire [14:0] ref_clock_khz_o,
    input wire [19:0] sample_rate_hz_o,
    input wire        sample_rate_ok_o,
    input wire [11:0] bits_per_frame_o,
    input wire        bits_per_frame_ok_o
);
    // One domain; nothing is judged while reset is held
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    // Bus answers one edge after a new request, low for one cycle only
    chk_wait_answer: assert property (
        $rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o) else $error("no bus answer");
    chk_wait_single: assert property (
        !avs_waitrequest_o |=> avs_waitrequest_o) else $error("waitrequest low too long");
    // Slot code splits into half and slot within half
    chk_slot_split: assert property (
        {chan5_right_half_o, chan5_half_slot_o} == chan5_slot_sel_o) else $error("slot split");
    // Clock decode consistency
    chk_pll_auto: assert property (
        pll_enable_o |-> auto_derive_o) else $error("pll on in custom mode");
    chk_gate_master: assert property (
        serial_clock_run_o |-> clock_role_sel_o) else $error("clocks sent as slave");
    chk_family_master: assert property (
        rate_family_sel_o |-> clock_role_sel_o) else $error("family used as slave");
    chk_ref_idle: assert property (
        !ref_from_table_o |-> ref_clock_khz_o == 15'h0000) else $error("ref freq not idle");
    chk_rate_valid: assert property (
        sample_rate_ok_o == (sample_rate_hz_o != 20'h00000)) else $error("rate ok flag");
    chk_ratio_valid: assert property (
        bits_per_frame_ok_o == (bits_per_frame_o != 12'h000)) else $error("ratio ok flag");

    // Main scenarios reached
    cov_write: cover property (avs_write_i && !avs_waitrequest_o);
    cov_clock_run: cover property (serial_clock_run_o && rate_family_sel_o);
    cov_right_half: cover property (chan5_right_half_o && ref_from_table_o);
endmodule

bind asc_cfg_bank asc_cfg_bank_sva i_asc_cfg_bank_sva (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
    .chan5_slot_sel_o(chan5_slot_sel_o), .chan5_right_half_o(chan5_right_half_o),
    .chan5_half_slot_o(chan5_half_slot_o), .clock_role_sel_o(clock_role_sel_o),
    .auto_derive_o(auto_derive_o), .pll_enable_o(pll_enable_o),
    .serial_clock_run_o(serial_clock_run_o), .rate_family_sel_o(rate_family_sel_o),
    .ref_from_table_o(ref_from_table_o), .ref_clock_khz_o(ref_clock_khz_o),
    .sample_rate_hz_o(sample_rate_hz_o), .sample_rate_ok_o(sample_rate_ok_o),
    .bits_per_frame_o(bits_per_frame_o), .bits_per_frame_ok_o(bits_per_frame_ok_o)
);

// ### sim/asc_cfg_bank_test.sv
/*
 * Self-checking bench for asc_cfg_bank: register access, slot and clock decode.
 * Assumes the design, the far host model and the checker are compiled before it.
 */
`timescale 1ns/1ps

module asc_cfg_bank_test;
    reg         sys_clk_i = 1'b0;
    reg         sys_rst_i = 1'b1;
    reg  [7:0]  adr = 8'h00;
    reg         rdq = 1'b0;
    reg         wrq = 1'b0;
    reg  [31:0] wd = 32'h00000000;
    reg  [3:0]  be = 4'hF;
    wire [31:0] rdat;
    wire [5:0]  c5s, c6s;
    wire [4:0]  c5h, c6h;
    wire        wait_r, c5l, c6l, c5r, c6r, role, auto, pll, run, fam, rtab, used, rok, bok;
    wire        hclk, href;
    wire [14:0] khz;
    wire [19:0] hz;
    wire [11:0] bpf;
    integer     fail_count = 0, compares = 0, cycles = 0, seed = 20428, i, r;
    integer     mult[0:8], bpf_t[0:15], khz_t[0:7];
    reg  [7:0]  v, w, s5, s6;
    reg  [31:0] exp_q[$];

    asc_cfg_bank #(.SIX_CHANNEL(1)) i_asc_cfg_bank (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(adr),
        .avs_read_i(rdq), .avs_write_i(wrq), .avs_writedata_i(wd), .avs_byteenable_i(be),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wait_r),
        .chan5_slot_sel_o(c5s), .chan5_out_line_sel_o(c5l), .chan5_right_half_o(c5r),
        .chan5_half_slot_o(c5h), .chan6_slot_sel_o(c6s), .chan6_out_line_sel_o(c6l),
        .chan6_right_half_o(c6r), .chan6_half_slot_o(c6h), .clock_role_sel_o(role),
        .auto_derive_o(auto), .pll_enable_o(pll), .serial_clock_run_o(run),
        .rate_family_sel_o(fam), .ref_from_table_o(rtab), .ref_clock_khz_o(khz),
        .rate_cfg_used_o(used), .sample_rate_hz_o(hz), .sample_rate_ok_o(rok),
        .bits_per_frame_o(bpf), .bits_per_frame_ok_o(bok));
    asc_far_host i_asc_far_host (.clock_role_sel_i(role), .ref_from_table_i(rtab),
        .host_drives_clk_o(hclk), .host_supplies_ref_o(href));

    // 50 MHz clock
    initial forever #10 sys_clk_i = ~sys_clk_i;

    task check(input [31:0] seen, input [31:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("Error at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task print_verdict;
        begin
            $display("Compares %0d, mismatches %0d", compares, fail_count);
            if (fail_count == 0 && compares > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask

    // Hold the request until waitrequest is sampled low, then one idle edge
    task bus(input rd, input [7:0] a, input [7:0] d, input [3:0] e);
        begin
            adr <= a;
            wd <= {24'h000000, d};
            be <= e;
            rdq <= rd;
            wrq <= !rd;
            @(posedge sys_clk_i);
            while (wait_r !== 1'b0) @(posedge sys_clk_i);
            rdq <= 1'b0;
            wrq <= 1'b0;
            @(posedge sys_clk_i);
        end
    endtask

    task rd(input [7:0] a, input [7:0] e);
        begin
            exp_q.push_back({24'h000000, e});
            bus(1'b1, a, 8'h00, 4'hF);
        end
    endtask

    // Extra edge lets the decoded outputs follow the register
    task wr(input [7:0] a, input [7:0] d, input [3:0] e);
        begin
            bus(1'b0, a, d, e);
            @(posedge sys_clk_i);
        end
    endtask

    task chk_cfg(input [7:0] c);
        begin
            check(role, c[7]);
            check(hclk, !c[7]);
            check(auto, !c[6]);
            check(pll, !c[6] && !c[5]);
            check(run, c[7] && !c[4]);
            check(fam, c[7] && c[3]);
            check(khz, c[7] ? khz_t[c[2:0]] : 0);
        end
    endtask

    // Each completed read is matched with the oldest expectation
    always @(posedge sys_clk_i) begin
        if (rdq && wait_r === 1'b0) begin
            if (exp_q.size() > 0) check(rdat, exp_q.pop_front());
            else check(32'h1, 32'h0);
        end
    end

    // Hang guard, far above the few hundred cycles needed
    always @(posedge sys_clk_i) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            fail_count = fail_count + 1;
            print_verdict;
        end
    end

    initial begin
        mult = '{1, 2, 3, 4, 6, 12, 24, 48, 96};
        bpf_t = '{16, 24, 32, 48, 64, 96, 128, 192, 256, 384, 512, 1024, 2048, 0, 144, 0};
        khz_t = '{12000, 12288, 13000, 16000, 19200, 19680, 24000, 24576};
        repeat (5) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        // Reset values
        check({c5l, c5s, c6l, c6s}, 14'h0205);
        check({hz, bpf}, {20'd48000, 12'd256});
        chk_cfg(8'h02);
        rd(8'h3C, 8'h04);
        rd(8'h40, 8'h05);
        rd(8'h4C, 8'h02);
        rd(8'h50, 8'h48);
        $display("Test reset done");
        // Slot boundaries 0, 31, 32, 63 then random codes, both output lines
        for (i = 0; i < 12; i = i + 1) begin
            r = $random(seed);
            v = r[7:0];
            if (i < 4) v[5:0] = {i[1], {5{i[0]}}};
            w = ~v;
            wr(8'h3C, v, 4'hF);
            wr(8'h40, w, 4'hF);
            check({c5l, c5r, c5h}, v[6:0]);
            check({c6l, c6s, c6r, c6h}, {w[6:0], w[5:0]});
            rd(8'h3C, v & 8'h7F);
            rd(8'h42, w & 8'h7F);
        end
        s5 = v & 8'h7F;
        s6 = w & 8'h7F;
        $display("Test slots done");
        // Every reference code as master, other bits random
        for (i = 0; i < 16; i = i + 1) begin
            r = $random(seed);
            v = r[7:0];
            v[2:0] = i[2:0];
            if (i < 8) v[7] = 1'b1;
            wr(8'h4C, v, 4'hF);
            chk_cfg(v);
            rd(8'h4C, v);
        end
        $display("Test clock config done");
        // Every rate and ratio code in the 44.1 kHz family
        wr(8'h4C, 8'h88, 4'hF);
        for (i = 0; i < 16; i = i + 1) begin
            v = {i[3:0], ~i[3:0]};
            wr(8'h50, v, 4'hF);
            check(hz, (v[7:4] > 8) ? 0 : 7350 * mult[v[7:4]]);
            check({rok, bok, used}, {v[7:4] < 9, v[3:0] != 13 && v[3:0] < 15, 1'b1});
            check(bpf, bpf_t[v[3:0]]);
            rd(8'h50, v);
        end
        $display("Test rate codes done");
        // Reference frequency mode, refused writes, unmapped word
        wr(8'h58, 8'hFF, 4'hF);
        check({rtab, khz, href}, 17'h0);
        rd(8'h58, 8'h40);
        wr(8'h58, 8'h00, 4'hF);
        check({rtab, khz, href}, {1'b1, 15'd12000, 1'b1});
        wr(8'h3C, 8'h3F, 4'hE);
        wr(8'h04, 8'hAA, 4'hF);
        check(c5s, s5[5:0]);
        rd(8'h3C, s5);
        rd(8'h40, s6);
        rd(8'h04, 8'h00);
        rd(8'h80, 8'h6F);
        wr(8'h4C, 8'h00, 4'hF);
        chk_cfg(8'h00);
        check(used, 1'b0);
        $display("Test refusals done");
        print_verdict;
    end
endmodule
